/* File: src/ipc_controller.v */
`include "ipc_defs.vh"
module ipc_controller #(
  parameter EXT_LINES = 4,
  parameter NAND_PINS = 4
)(
  input  wire                 sys_clk,
  input  wire                 rst,
  input  wire [3:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  input  wire [EXT_LINES-1:0] ext_irq_line,
  input  wire [NAND_PINS-1:0] nand_pin,
  input  wire [NAND_PINS-1:0] nand_pin_irq_en,
  input  wire [5:0]           periph_flag,
  input  wire [5:0]           periph_clear,
  input  wire                 insn_end,
  input  wire                 trap_insn,
  input  wire                 return_from_irq_instruction,
  input  wire                 mask_set_insn,
  input  wire                 mask_clear_insn,
  output reg                  irq_entry_ff,
  output reg  [15:0]          program_counter_ff,
  output reg                  ctx_push_ff,
  output reg                  ctx_pop_ff,
  output reg                  global_mask_ff,
  output reg                  wake_ff
);
  // sequencer states
  localparam SEQ_IDLE  = 2'h0;
  localparam SEQ_PUSH  = 2'h1;
  localparam SEQ_FETCH = 2'h2;
  localparam SEQ_POP   = 2'h3;
  // source codes kept beside the chosen vector
  localparam SRC_NONE  = 4'h0;
  localparam SRC_RESET = 4'hF;
  localparam SRC_TRAP  = 4'hE;

  reg  [1:0]           state_ff;
  reg  [1:0]           nxt_state;
  reg  [7:0]           ext_irq_sense_register_ff;
  reg  [EXT_LINES-1:0] ext_pend_ff;
  reg  [EXT_LINES-1:0] ext_prev_ff;
  reg  [5:0]           periph_en_ff;
  reg  [5:0]           periph_pend_ff;
  reg                  trap_pend_ff;
  reg                  reset_pend_ff;
  reg                  wait_mode_ff;
  reg                  halt_mode_ff;
  reg  [15:0]          sel_vec;
  reg                  sel_valid;
  reg  [3:0]           sel_src;
  // vector and source captured when an entry is decided
  reg  [15:0]          entry_vec_ff;
  reg  [3:0]           entry_src_ff;
  wire [EXT_LINES-1:0] ext_in;
  wire [EXT_LINES-1:0] ext_level;
  wire                 nand_block;
  wire                 sense_wr;
  wire [5:0]           periph_live;
  wire                 any_req;
  wire                 halt_req;
  wire                 trap_now;
  wire                 take;

  // nand group on line 0: a low pin enabled for irq blocks the request
  assign nand_block = |(~nand_pin & nand_pin_irq_en);
  assign ext_in     = {ext_irq_line[EXT_LINES-1:1], ext_irq_line[0] & ~nand_block};
  assign sense_wr   = reg_wr && (reg_addr == `IPC_ADDR_SENSE) && global_mask_ff;

  // per-line edge detection and latching
  genvar i;
  generate
    for (i = 0; i < EXT_LINES; i = i + 1)
    begin : g_ext
      wire [1:0] mode = ext_irq_sense_register_ff[2*i+1:2*i];
      wire       rise = ext_in[i] & ~ext_prev_ff[i];
      wire       fall = ~ext_in[i] & ext_prev_ff[i];
      wire       hit  = (mode == `IPC_SENSE_RISE) ? rise :
                        (mode == `IPC_SENSE_FALL) ? fall :
                        (mode == `IPC_SENSE_BOTH) ? (rise | fall) : fall;
      wire       chg  = sense_wr && (reg_wdata[2*i+1:2*i] != mode);
      wire       done = irq_entry_ff && (entry_src_ff == i + 1);
      assign ext_level[i] = (mode == `IPC_SENSE_FALL_LOW) & ~ext_in[i];
      // a new edge outranks both the sense-change clear and the entry clear
      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          ext_prev_ff[i] <= 1'b1;   // idle level of the pins, no false edge after reset
          ext_pend_ff[i] <= 1'b0;
        end
        else
        begin
          ext_prev_ff[i] <= ext_in[i];
          if (hit)
            ext_pend_ff[i] <= 1'b1;
          else if (chg)
            ext_pend_ff[i] <= 1'b0;
          else if (done)
            ext_pend_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // peripheral latches: set wins over the software clear sequence
  assign periph_live = periph_pend_ff & periph_en_ff;

  always @(posedge sys_clk)
  begin
    if (rst)
      periph_pend_ff <= 6'h00;
    else
      periph_pend_ff <= periph_flag | (periph_pend_ff & ~periph_clear);
  end

  // fixed priority selection
  always @*
  begin
    sel_valid = 1'b1;
    sel_src   = SRC_NONE;
    sel_vec   = `IPC_VEC_RESET;
    if (reset_pend_ff)
    begin
      sel_vec = `IPC_VEC_RESET;
      sel_src = SRC_RESET;
    end
    else if (trap_pend_ff || trap_now)
    begin
      sel_vec = `IPC_VEC_TRAP;
      sel_src = SRC_TRAP;
    end
    else if (global_mask_ff)
      sel_valid = 1'b0;
    else if (ext_pend_ff[0] | ext_level[0])
    begin
      sel_vec = `IPC_VEC_EXT0;
      sel_src = 4'h1;
    end
    else if (ext_pend_ff[1] | ext_level[1])
    begin
      sel_vec = `IPC_VEC_EXT1;
      sel_src = 4'h2;
    end
    else if (ext_pend_ff[2] | ext_level[2])
    begin
      sel_vec = `IPC_VEC_EXT2;
      sel_src = 4'h3;
    end
    else if (ext_pend_ff[3] | ext_level[3])
    begin
      sel_vec = `IPC_VEC_EXT3;
      sel_src = 4'h4;
    end
    else if (periph_live[0])
    begin
      sel_vec = `IPC_VEC_SUPPLY;
      sel_src = 4'h7;
    end
    else if (periph_live[1])
    begin
      sel_vec = `IPC_VEC_AR_CMP;
      sel_src = 4'h8;
    end
    else if (periph_live[2])
    begin
      sel_vec = `IPC_VEC_AR_OVF;
      sel_src = 4'h9;
    end
    else if (periph_live[3])
    begin
      sel_vec = `IPC_VEC_BT_CAP;
      sel_src = 4'hA;
    end
    else if (periph_live[4])
    begin
      sel_vec = `IPC_VEC_BT_RTB;
      sel_src = 4'hB;
    end
    else if (periph_live[5])
    begin
      sel_vec = `IPC_VEC_SERIAL;
      sel_src = 4'hC;
    end
    else
      sel_valid = 1'b0;
  end

  // wake sources for the low-power modes
  assign any_req  = (|ext_pend_ff) | (|ext_level) | (|periph_live);
  assign halt_req = (|ext_pend_ff) | (|ext_level) | (|(periph_live & `IPC_PERIPH_HALT_OK));

  // a trap is taken at the end of its own instruction, whatever the mask
  assign trap_now = insn_end && trap_insn;
  // decision edge: idle now and pushing next
  assign take     = (state_ff == SEQ_IDLE) && (nxt_state == SEQ_PUSH);

  // entry and return sequencer
  always @*
  begin
    case (state_ff)
      SEQ_IDLE:
        if ((insn_end || wake_ff) && sel_valid)
          nxt_state = SEQ_PUSH;
        else if (insn_end && return_from_irq_instruction)
          nxt_state = SEQ_POP;
        else
          nxt_state = SEQ_IDLE;
      SEQ_PUSH:  nxt_state = SEQ_FETCH;
      default:   nxt_state = SEQ_IDLE;
    endcase
  end

  // vector and source frozen at the decision edge, so that a mask change
  // or a level that goes away during the push cannot move the target
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      entry_vec_ff <= `IPC_VEC_RESET;
      entry_src_ff <= SRC_NONE;
    end
    else if (take)
    begin
      entry_vec_ff <= sel_vec;
      entry_src_ff <= sel_src;
    end
  end

  // trap latch: a new trap outranks the clear of an older one being taken
  always @(posedge sys_clk)
  begin
    if (rst)
      trap_pend_ff <= 1'b0;
    else if (trap_now && (trap_pend_ff || !(take && sel_src == SRC_TRAP)))
      trap_pend_ff <= 1'b1;
    else if (take && sel_src == SRC_TRAP)
      trap_pend_ff <= 1'b0;
  end

  // reset request stays pending until its own vector is taken
  always @(posedge sys_clk)
  begin
    if (rst)
      reset_pend_ff <= 1'b1;
    else if (take && sel_src == SRC_RESET)
      reset_pend_ff <= 1'b0;
  end

  // state, mask, program counter and mode control
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff           <= SEQ_IDLE;
      global_mask_ff     <= 1'b1;
      irq_entry_ff       <= 1'b0;
      ctx_push_ff        <= 1'b0;
      ctx_pop_ff         <= 1'b0;
      program_counter_ff <= 16'h0000;
      wait_mode_ff       <= 1'b0;
      halt_mode_ff       <= 1'b0;
      wake_ff            <= 1'b0;
      periph_en_ff       <= `IPC_PERIPH_EN_RST;
      ext_irq_sense_register_ff <= `IPC_SENSE_RST;
    end
    else
    begin
      // one-cycle pulses and the wake level toward the core; the reset entry saves no context
      state_ff     <= nxt_state;
      ctx_push_ff  <= take && (sel_src != SRC_RESET);
      ctx_pop_ff   <= (nxt_state == SEQ_POP);
      irq_entry_ff <= (state_ff == SEQ_PUSH);
      wake_ff      <= (wait_mode_ff && any_req) || (halt_mode_ff && halt_req);
      // mask: entry sets it, return clears it, then the core's own set and clear
      if (state_ff == SEQ_PUSH)
      begin
        program_counter_ff <= entry_vec_ff;
        global_mask_ff     <= 1'b1;
        wait_mode_ff       <= 1'b0;
        halt_mode_ff       <= 1'b0;
      end
      else if (state_ff == SEQ_POP)
        global_mask_ff <= 1'b0;
      else if (mask_set_insn)
        global_mask_ff <= 1'b1;
      else if (mask_clear_insn)
        global_mask_ff <= 1'b0;
      // software writes to the control, enable and sense registers
      if (reg_wr && reg_addr == `IPC_ADDR_CTRL)
      begin
        wait_mode_ff <= reg_wdata[`IPC_CTRL_WAIT_BIT];
        halt_mode_ff <= reg_wdata[`IPC_CTRL_HALT_BIT];
      end
      if (reg_wr && reg_addr == `IPC_ADDR_PERIPH_EN)
        periph_en_ff <= reg_wdata[5:0];
      if (sense_wr)
        ext_irq_sense_register_ff <= reg_wdata;
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `IPC_ADDR_SENSE:     reg_rdata <= ext_irq_sense_register_ff;
        `IPC_ADDR_CTRL:      reg_rdata <= {5'h00, halt_mode_ff, wait_mode_ff, global_mask_ff};
        `IPC_ADDR_PEND:      reg_rdata <= {{(8-EXT_LINES){1'b0}}, ext_pend_ff};
        `IPC_ADDR_PERIPH_EN: reg_rdata <= {2'h0, periph_en_ff};
        `IPC_ADDR_STATUS:    reg_rdata <= {2'h0, periph_pend_ff};
        `IPC_ADDR_VEC_LO:    reg_rdata <= program_counter_ff[7:0];
        `IPC_ADDR_VEC_HI:    reg_rdata <= program_counter_ff[15:8];
        default:             reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule

/* File: src/ipc_defs.vh */
`ifndef IPC_DEFS_VH
`define IPC_DEFS_VH
// register offsets on the plain register port
`define IPC_ADDR_SENSE      4'h0
`define IPC_ADDR_CTRL       4'h1
`define IPC_ADDR_PEND       4'h2
`define IPC_ADDR_PERIPH_EN  4'h3
`define IPC_ADDR_STATUS     4'h4
`define IPC_ADDR_VEC_LO     4'h5
`define IPC_ADDR_VEC_HI     4'h6
// control register fields
`define IPC_CTRL_MASK_BIT   0
`define IPC_CTRL_WAIT_BIT   1
`define IPC_CTRL_HALT_BIT   2
// reset values
`define IPC_SENSE_RST       8'h00
`define IPC_PERIPH_EN_RST   6'h00
// sense modes
`define IPC_SENSE_FALL_LOW  2'h0
`define IPC_SENSE_RISE      2'h1
`define IPC_SENSE_FALL      2'h2
`define IPC_SENSE_BOTH      2'h3
// vectors
`define IPC_VEC_RESET       16'hFFFE
`define IPC_VEC_TRAP        16'hFFFC
`define IPC_VEC_EXT0        16'hFFF8
`define IPC_VEC_EXT1        16'hFFF6
`define IPC_VEC_EXT2        16'hFFF4
`define IPC_VEC_EXT3        16'hFFF2
`define IPC_VEC_SUPPLY      16'hFFEC
`define IPC_VEC_AR_CMP      16'hFFEA
`define IPC_VEC_AR_OVF      16'hFFE8
`define IPC_VEC_BT_CAP      16'hFFE6
`define IPC_VEC_BT_RTB      16'hFFE4
`define IPC_VEC_SERIAL      16'hFFE2
// halt wake capability per peripheral bit: only overflow, time base and serial
`define IPC_PERIPH_HALT_OK  6'h34
`endif

/* File: dv/ipc_chk_asserts.sv */
module ipc_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        insn_end,
  input wire logic        trap_insn,
  input wire logic        irq_entry_ff,
  input wire logic [15:0] program_counter_ff,
  input wire logic        ctx_push_ff,
  input wire logic        ctx_pop_ff,
  input wire logic        global_mask_ff
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RST_MASK: assert property ($fell(rst) |-> global_mask_ff)
    else $error("mask clear after reset");
  AST_PUSH_ENTRY: assert property (ctx_push_ff |=> irq_entry_ff && global_mask_ff)
    else $error("push not followed by masked entry");
  AST_ENTRY_PUSHED: assert property (irq_entry_ff && program_counter_ff != 16'hFFFE |-> $past(ctx_push_ff))
    else $error("entry without context push");
  AST_ENTRY_GAP: assert property (irq_entry_ff |=> !irq_entry_ff [*2])
    else $error("entries too close");
  AST_VEC_LEGAL: assert property (irq_entry_ff |-> program_counter_ff inside {16'hFFFE, 16'hFFFC, 16'hFFF8,
    16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2})
    else $error("entry to unused vector");
  AST_POP_UNMASK: assert property (ctx_pop_ff |=> !global_mask_ff)
    else $error("mask still set after return");
  AST_TRAP: assert property (insn_end && trap_insn |-> ##[1:4] irq_entry_ff && program_counter_ff == 16'hFFFC)
    else $error("trap not entered");
  AST_MASKED_NO_ENTRY: assert property (irq_entry_ff && program_counter_ff < 16'hFFFC |-> !$past(global_mask_ff, 2))
    else $error("maskable entry while masked");
endmodule

bind ipc_controller ipc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .insn_end(insn_end), .trap_insn(trap_insn),
  .irq_entry_ff(irq_entry_ff), .program_counter_ff(program_counter_ff), .ctx_push_ff(ctx_push_ff),
  .ctx_pop_ff(ctx_pop_ff), .global_mask_ff(global_mask_ff));

/* File: dv/ipc_cpu_model.sv */
module ipc_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] op,
  output logic            insn_end,
  output logic            trap_insn,
  output logic            ret_insn,
  output logic            sei_insn,
  output logic            cli_insn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_ff;

  // retire an instruction every fourth cycle, or the one the bench asks for
  always_ff @(posedge sys_clk)
  begin
    cnt_ff    <= rst ? 2'h0 : cnt_ff + 2'h1;
    insn_end  <= !rst && (op != 3'h0 || cnt_ff == 2'h3);
    trap_insn <= !rst && op == 3'h1;
    ret_insn  <= !rst && op == 3'h2;
    sei_insn  <= !rst && op == 3'h3;
    cli_insn  <= !rst && op == 3'h4;
  end
endmodule

/* File: dv/interrupt_priority_controller_tb_top.sv */
module interrupt_priority_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [3:0]  ext_irq_line = 4'hF;
  logic [3:0]  nand_pin = 4'hF;
  logic [3:0]  nand_pin_irq_en = 4'h0;
  logic [5:0]  periph_flag = 6'h00;
  logic [5:0]  periph_clear = 6'h00;
  logic [2:0]  op = 3'h0;
  logic        insn_end, trap_insn, ret_insn, sei_insn, cli_insn;
  logic        irq_entry_ff, ctx_push_ff, ctx_pop_ff, global_mask_ff, wake_ff;
  logic [15:0] program_counter_ff;
  logic [15:0] pv [5] = '{16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4};
  int          miscompares = 0;
  int          checks_done = 0;

  ipc_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .op(op), .insn_end(insn_end), .trap_insn(trap_insn),
    .ret_insn(ret_insn), .sei_insn(sei_insn), .cli_insn(cli_insn));
  ipc_controller dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_line(ext_irq_line),
    .nand_pin(nand_pin), .nand_pin_irq_en(nand_pin_irq_en), .periph_flag(periph_flag),
    .periph_clear(periph_clear), .insn_end(insn_end), .trap_insn(trap_insn),
    .return_from_irq_instruction(ret_insn), .mask_set_insn(sei_insn), .mask_clear_insn(cli_insn),
    .irq_entry_ff(irq_entry_ff), .program_counter_ff(program_counter_ff), .ctx_push_ff(ctx_push_ff),
    .ctx_pop_ff(ctx_pop_ff), .global_mask_ff(global_mask_ff), .wake_ff(wake_ff));

  // 25 MHz clock
  initial forever #20 sys_clk = ~sys_clk;

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask

  // one-cycle pulses on peripheral flags and clears, and core instructions
  task pf(input logic [5:0] f, input logic [5:0] c);
    @(posedge sys_clk);
    periph_flag <= f;
    periph_clear <= c;
    @(posedge sys_clk);
    periph_flag <= 6'h00;
    periph_clear <= 6'h00;
  endtask

  task cpu_op(input logic [2:0] c);
    @(posedge sys_clk);
    op <= c;
    @(posedge sys_clk);
    op <= 3'h0;
  endtask

  // bounded wait for an entry, then compare the vector
  task went(input logic [15:0] v);
    int n;
    n = 0;
    #1;
    while (irq_entry_ff !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("entry", {15'h0, irq_entry_ff}, 16'h1);
    chk("vector", program_counter_ff, v);
    if (n == 60)
      results();
  endtask

  task quiet;
    repeat (20)
    begin
      @(posedge sys_clk);
      #1;
      chk("entry", {15'h0, irq_entry_ff}, 16'h0);
    end
  endtask

  task t_boot;
    chk("mask", {15'h0, global_mask_ff}, 16'h1);
    went(16'hFFFE);
    rd(4'h1, 8'h01);
    $display("boot done");
  endtask

  task t_trap;
    cpu_op(3'h1);
    went(16'hFFFC);
    cpu_op(3'h2);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("mask", {15'h0, global_mask_ff}, 16'h0);
    $display("trap done");
  endtask

  task t_periph;
    cpu_op(3'h3);
    wr(4'h3, 8'h1F);
    pf(6'h3F, 6'h00);
    pf(6'h00, 6'h20);
    quiet();
    cpu_op(3'h4);
    for (int i = 0; i < 5; i++)
    begin
      went(pv[i]);
      pf(6'h00, 6'h01 << i);
      cpu_op(3'h2);
    end
    wr(4'h3, 8'h3F);
    quiet();
    rd(4'h4, 8'h00);
    $display("peripheral done");
  endtask

  task t_ext;
    cpu_op(3'h3);
    wr(4'h0, 8'h55);
    rd(4'h0, 8'h55);
    cpu_op(3'h4);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h55);
    cpu_op(3'h3);
    @(posedge sys_clk);
    ext_irq_line <= 4'h0;
    nand_pin <= 4'hE;
    nand_pin_irq_en <= 4'h1;
    @(posedge sys_clk);
    ext_irq_line <= 4'h3;
    rd(4'h2, 8'h02);
    wr(4'h0, 8'h59);
    rd(4'h2, 8'h00);
    @(posedge sys_clk);
    ext_irq_line <= 4'h7;
    rd(4'h2, 8'h04);
    cpu_op(3'h4);
    went(16'hFFF4);
    rd(4'h2, 8'h00);
    cpu_op(3'h2);
    $display("external done");
  endtask

  task t_halt;
    cpu_op(3'h3);
    wr(4'h1, 8'h05);
    pf(6'h01, 6'h00);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("wake", {15'h0, wake_ff}, 16'h0);
    pf(6'h04, 6'h01);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("wake", {15'h0, wake_ff}, 16'h1);
    pf(6'h00, 6'h04);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("wake", {15'h0, wake_ff}, 16'h0);
    wr(4'h1, 8'h02);
    pf(6'h01, 6'h00);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("wake", {15'h0, wake_ff}, 16'h1);
    $display("halt done");
  endtask

  // reset for ten cycles, then the scenarios in order
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_boot();
    t_trap();
    t_periph();
    t_ext();
    t_halt();
    results();
  end
endmodule
